// ==== verilog/analog_alarm_record.sv ====
// Analog alarm record: twelve registers plus pickup and dropout evaluation
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Twelve consecutive 16-bit registers form the record, same field order always.
// - Upper byte of first register: zero enables alarm, one disables it.
// - Lower byte of first register is priority, only zero to three accepted.
// - After reset the first register reads disabled with priority one.
// - First register equal to zero suppresses event log and waveform capture.
// - Second register is read-only monitored register number, default 1016.
// - Third register: upper byte pickup mode, lower byte dropout mode.
// - Mode bytes are 1 immediate, 2 direct, 4 bit test; immediate default.
// - Immediate mode compares monitored value with the literal pickup or release threshold.
// - Direct mode compares against a referenced register scaled by a percentage.
// - Multipliers are read-only percents used only in direct mode, default 0x8000.
// - Bit test mode ANDs the threshold mask with the monitored value.
// - Pickup threshold register is writable and resets to 0x8000.
// - Alarm rises only after pickup held for the actuation delay in seconds.
// - Writable release threshold defines the dropout value, resets to 0x8000.
// - Read-only type: 0 over, 1 under, 2 equal, 3 different, 5 other.
// - Action bit 9 set logs waveform capture when actuation delay expires.
module analog_alarm_record import alarm_pkg::*; #(
    parameter int TICK_CYCLES = SEC_CYCLES,
    parameter logic [15:0] MON_NUM = RST_MON_NUM,
    parameter logic [15:0] MODES = RST_MODES,
    parameter logic [15:0] PICK_MULT = RST_MULT,
    parameter logic [15:0] REL_MULT = RST_MULT,
    parameter logic [15:0] ALARM_TYPE = RST_TYPE
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    input wire logic [15:0] mon_value,
    input wire logic [15:0] pick_ref_value,
    input wire logic [15:0] rel_ref_value,
    output logic [15:0] mon_reg_num,
    output logic [15:0] pick_ref_num,
    output logic [15:0] rel_ref_num,
    output logic alarm_active,
    output logic event_log,
    output logic wave_capture
);
    function automatic logic mode_ok(input logic [7:0] m);
        return (m == MODE_IMM) || (m == MODE_DIRECT) || (m == MODE_BITTEST);
    endfunction

    if (!mode_ok(MODES[15:8]) || !mode_ok(MODES[7:0])) begin : g_bad_mode
        $error("Comparison mode byte must be 1, 2 or 4");
    end
    if (ALARM_TYPE > TYPE_DIFF && ALARM_TYPE != TYPE_OTHER) begin : g_bad_type
        $error("Alarm type must be 0 to 3 or 5");
    end
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("Tick divider needs at least one cycle");
    end

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // Writable registers, bus answer, output, divider and sequencer state
    logic [15:0] act_pri_r;
    logic [15:0] pick_thr_r;
    logic [15:0] pick_dly_r;
    logic [15:0] rel_thr_r;
    logic [15:0] rel_dly_r;
    logic [15:0] action_r;
    logic [15:0] reg_rdata_r;
    logic reg_ack_r;
    logic reg_err_r;
    logic alarm_active_r;
    logic event_log_r;
    logic wave_capture_r;
    logic [31:0] div_r;
    logic tick_r;
    alarm_state_t state_r;
    alarm_state_t state_nxt;

    delay_if dly ();

    // Type compare used for immediate and direct modes
    function automatic logic type_hit(input logic [15:0] t, input logic [31:0] a,
                                      input logic [31:0] b);
        logic r;
        r = 1'b0;
        case (t)
            TYPE_UNDER: r = (a < b);
            TYPE_EQUAL: r = (a == b);
            TYPE_DIFF: r = (a != b);
            default: r = (a > b);
        endcase
        return r;
    endfunction

    // Test of one comparison mode, used for both pickup and dropout
    function automatic logic mode_hit(input logic [7:0] m, input logic [15:0] t,
                                      input logic [15:0] mon, input logic [15:0] thr,
                                      input logic [15:0] refv, input logic [15:0] mult);
        logic r;
        logic [31:0] lhs;
        logic [31:0] rhs;
        r = 1'b0;
        lhs = 32'(mon) * PCT_SCALE;
        rhs = 32'(refv) * 32'(mult);
        case (m)
            MODE_IMM: r = type_hit(t, 32'(mon), 32'(thr));
            MODE_DIRECT: r = type_hit(t, lhs, rhs);
            MODE_BITTEST: r = |(mon & thr);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Address decode
    wire hit_act = (reg_addr == OFS_ACT_PRI);
    wire hit_pthr = (reg_addr == OFS_PICK_THR);
    wire hit_pdly = (reg_addr == OFS_PICK_DLY);
    wire hit_rthr = (reg_addr == OFS_REL_THR);
    wire hit_rdly = (reg_addr == OFS_REL_DLY);
    wire hit_actn = (reg_addr == OFS_ACTION);
    wire in_rec = (reg_addr >= OFS_ACT_PRI) && (reg_addr <= OFS_RSVD);
    wire wr = reg_req && reg_we;

    // per-byte validity of the first register
    wire act_byte_ok = (reg_wdata[ACT_MSB:ACT_LSB] <= ACT_OFF);
    wire pri_byte_ok = (reg_wdata[PRI_MSB:PRI_LSB] <= PRI_MAX);
    wire [15:0] act_pri_nxt = {act_byte_ok ? reg_wdata[ACT_MSB:ACT_LSB]
                                           : act_pri_r[ACT_MSB:ACT_LSB],
                               pri_byte_ok ? reg_wdata[PRI_MSB:PRI_LSB]
                                           : act_pri_r[PRI_MSB:PRI_LSB]};

    // read-only fields answer their fixed values, reserved reads zero
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (reg_addr)
            OFS_ACT_PRI: rd_mux = act_pri_r;
            OFS_MON_NUM: rd_mux = MON_NUM;
            OFS_MODES: rd_mux = MODES;
            OFS_PICK_THR: rd_mux = pick_thr_r;
            OFS_PICK_MULT: rd_mux = PICK_MULT;
            OFS_PICK_DLY: rd_mux = pick_dly_r;
            OFS_REL_THR: rd_mux = rel_thr_r;
            OFS_REL_MULT: rd_mux = REL_MULT;
            OFS_REL_DLY: rd_mux = rel_dly_r;
            OFS_TYPE: rd_mux = ALARM_TYPE;
            OFS_ACTION: rd_mux = action_r;
            default: rd_mux = 16'h0000;
        endcase
    end

    wire alarm_on = (act_pri_r[ACT_MSB:ACT_LSB] == ACT_ON);
    wire log_ok = (act_pri_r != 16'h0000);

    wire pick_cond = mode_hit(MODES[15:8], ALARM_TYPE, mon_value, pick_thr_r,
                              pick_ref_value, PICK_MULT);
    // dropout judged against the release threshold
    wire drop_cond = !mode_hit(MODES[7:0], ALARM_TYPE, mon_value, rel_thr_r,
                               rel_ref_value, REL_MULT);

    // release delay clamped to its longest value
    wire [15:0] rel_lim = (rel_dly_r > REL_DLY_MAX_S) ? REL_DLY_MAX_S : rel_dly_r;

    // Timer runs only while the watched condition holds in its own phase
    assign dly.run = (state_r == ST_PICK && pick_cond) ||
                     (state_r == ST_REL && drop_cond);
    assign dly.tick = tick_r;
    assign dly.limit = (state_r == ST_REL) ? rel_lim : pick_dly_r;

    delay_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dly(dly)
    );

    // Sequencer; the ACTIVE stay of one cycle lets the timer restart
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (pick_cond) state_nxt = ST_PICK;
            ST_PICK: begin
                if (!pick_cond) state_nxt = ST_IDLE;
                else if (dly.done) state_nxt = ST_ACTIVE;
            end
            ST_ACTIVE: if (drop_cond) state_nxt = ST_REL;
            ST_REL: begin
                if (!drop_cond) state_nxt = ST_ACTIVE;
                else if (dly.done) state_nxt = ST_IDLE;
            end
        endcase
        if (!alarm_on) state_nxt = ST_IDLE;
    end

    wire fire = alarm_on && (state_r == ST_PICK) && pick_cond && dly.done;

    // One-second enable; long divide so a simulation may shorten it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else begin
            div_r <= (div_r >= TICK_LAST) ? 32'h0000_0000 : div_r + 32'h0000_0001;
            tick_r <= (div_r >= TICK_LAST);
        end
    end

    // writable fields and their reset values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_pri_r <= RST_ACT_PRI;
            pick_thr_r <= RST_PICK_THR;
            pick_dly_r <= RST_PICK_DLY;
            rel_thr_r <= RST_REL_THR;
            rel_dly_r <= RST_REL_DLY;
            action_r <= RST_ACTION;
        end else if (wr) begin
            if (hit_act) act_pri_r <= act_pri_nxt;
            if (hit_pthr) pick_thr_r <= reg_wdata;
            if (hit_pdly) pick_dly_r <= reg_wdata;
            if (hit_rthr) rel_thr_r <= reg_wdata;
            if (hit_rdly) rel_dly_r <= reg_wdata;
            if (hit_actn) action_r <= reg_wdata;
        end
    end

    // Answer one cycle after each request; outside the record flags an error
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 16'h0000;
            reg_ack_r <= 1'b0;
            reg_err_r <= 1'b0;
        end else begin
            reg_ack_r <= reg_req;
            reg_err_r <= reg_req && !in_rec;
            if (reg_req && !reg_we) reg_rdata_r <= rd_mux;
        end
    end

    // event and capture pulses at the end of the actuation delay
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            alarm_active_r <= 1'b0;
            event_log_r <= 1'b0;
            wave_capture_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            alarm_active_r <= alarm_on &&
                              (state_nxt == ST_ACTIVE || state_nxt == ST_REL);
            event_log_r <= fire && log_ok;
            wave_capture_r <= fire && log_ok && action_r[ACTION_WAVE_BIT];
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign reg_ack = reg_ack_r;
    assign reg_err = reg_err_r;
    assign alarm_active = alarm_active_r;
    assign event_log = event_log_r;
    assign wave_capture = wave_capture_r;
    // fixed monitored number; threshold registers double as reference numbers
    assign mon_reg_num = MON_NUM;
    assign pick_ref_num = pick_thr_r;
    assign rel_ref_num = rel_thr_r;

    a_ack_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_req |=> reg_ack_r)
        else $error("Request not answered next cycle");
    a_act_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        act_pri_r[ACT_MSB:ACT_LSB] <= ACT_OFF)
        else $error("Activity byte out of range");
    a_pri_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        act_pri_r[PRI_MSB:PRI_LSB] <= PRI_MAX)
        else $error("Priority byte out of range");
    a_off_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (act_pri_r[ACT_MSB:ACT_LSB] == ACT_OFF) |=> !alarm_active_r && !event_log_r)
        else $error("Disabled alarm became active");
    a_zero_nolog: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (event_log_r || wave_capture_r) |-> $past(act_pri_r) != 16'h0000)
        else $error("Logged with first register zero");
    a_mon_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req && !reg_we && reg_addr == OFS_MON_NUM) |=> reg_rdata_r == MON_NUM)
        else $error("Monitored number read wrong");
    a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req && !reg_we && reg_addr == OFS_RSVD) |=> reg_rdata_r == 16'h0000)
        else $error("Reserved register not zero");
    a_pick_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && hit_pthr) |=> pick_thr_r == $past(reg_wdata))
        else $error("Pickup threshold write lost");
    a_rise_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(alarm_active_r) |-> $past(state_r == ST_PICK && dly.done))
        else $error("Alarm rose before actuation delay");
    a_rise_log: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wave_capture_r |-> $past(action_r[ACTION_WAVE_BIT]) && $rose(alarm_active_r))
        else $error("Capture without action bit or alarm rise");
    a_rel_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_REL) |-> dly.limit <= REL_DLY_MAX_S)
        else $error("Release delay above its ceiling");
    a_fall_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(alarm_active_r) && $past(alarm_on)) |-> $past(state_r == ST_REL && dly.done))
        else $error("Alarm cleared before release delay");
    a_modes_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req && !reg_we && reg_addr == OFS_MODES) |=> reg_rdata_r == MODES)
        else $error("Comparison modes read wrong");
    a_type_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req && !reg_we && reg_addr == OFS_TYPE) |=> reg_rdata_r == ALARM_TYPE)
        else $error("Alarm type read wrong");
    a_pmult_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req && !reg_we && reg_addr == OFS_PICK_MULT) |=> reg_rdata_r == PICK_MULT)
        else $error("Pickup multiplier read wrong");
    a_rmult_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req && !reg_we && reg_addr == OFS_REL_MULT) |=> reg_rdata_r == REL_MULT)
        else $error("Release multiplier read wrong");
    a_act_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && hit_act && reg_wdata[ACT_MSB:ACT_LSB] <= ACT_OFF &&
         reg_wdata[PRI_MSB:PRI_LSB] <= PRI_MAX) |=> act_pri_r == $past(reg_wdata))
        else $error("Valid first register write lost");
    a_pri_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && hit_act && reg_wdata[PRI_MSB:PRI_LSB] > PRI_MAX) |=>
        act_pri_r[PRI_MSB:PRI_LSB] == $past(act_pri_r[PRI_MSB:PRI_LSB]))
        else $error("Bad priority accepted");
    a_rel_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr && hit_rthr) |=> rel_thr_r == $past(reg_wdata))
        else $error("Release threshold write lost");
    a_pulse_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        event_log_r |=> !event_log_r)
        else $error("Event pulse longer than one cycle");
endmodule // analog_alarm_record
`default_nettype wire

// ==== verilog/alarm_pkg.sv ====
// Constants shared by the analog alarm record and its delay timer
package alarm_pkg;
    // Record layout, twelve 16-bit registers
    localparam int REC_WORDS = 12;
    localparam logic [15:0] OFS_ACT_PRI = 16'h176f;
    localparam logic [15:0] OFS_MON_NUM = 16'h1770;
    localparam logic [15:0] OFS_MODES = 16'h1771;
    localparam logic [15:0] OFS_PICK_THR = 16'h1772;
    localparam logic [15:0] OFS_PICK_MULT = 16'h1773;
    localparam logic [15:0] OFS_PICK_DLY = 16'h1774;
    localparam logic [15:0] OFS_REL_THR = 16'h1775;
    localparam logic [15:0] OFS_REL_MULT = 16'h1776;
    localparam logic [15:0] OFS_REL_DLY = 16'h1777;
    localparam logic [15:0] OFS_TYPE = 16'h1778;
    localparam logic [15:0] OFS_ACTION = 16'h1779;
    localparam logic [15:0] OFS_RSVD = 16'h177a;

    // Values after reset
    localparam logic [15:0] RST_ACT_PRI = 16'h0101;
    localparam logic [15:0] RST_MON_NUM = 16'h03f8;
    localparam logic [15:0] RST_MODES = 16'h0101;
    localparam logic [15:0] RST_PICK_THR = 16'h8000;
    localparam logic [15:0] RST_MULT = 16'h8000;
    localparam logic [15:0] RST_PICK_DLY = 16'h8000;
    localparam logic [15:0] RST_REL_THR = 16'h8000;
    localparam logic [15:0] RST_REL_DLY = 16'h8000;
    localparam logic [15:0] RST_TYPE = 16'h0001;
    localparam logic [15:0] RST_ACTION = 16'h0000;

    // Field layout
    localparam int ACT_MSB = 15;
    localparam int ACT_LSB = 8;
    localparam int PRI_MSB = 7;
    localparam int PRI_LSB = 0;
    localparam logic [7:0] ACT_ON = 8'h00;
    localparam logic [7:0] ACT_OFF = 8'h01;
    localparam logic [7:0] PRI_MAX = 8'h03;
    localparam int ACTION_WAVE_BIT = 9;

    // Comparison mode codes
    localparam logic [7:0] MODE_IMM = 8'h01;
    localparam logic [7:0] MODE_DIRECT = 8'h02;
    localparam logic [7:0] MODE_BITTEST = 8'h04;

    // Alarm type codes
    localparam logic [15:0] TYPE_OVER = 16'h0000;
    localparam logic [15:0] TYPE_UNDER = 16'h0001;
    localparam logic [15:0] TYPE_EQUAL = 16'h0002;
    localparam logic [15:0] TYPE_DIFF = 16'h0003;
    localparam logic [15:0] TYPE_OTHER = 16'h0005;

    // Percent scale of the multipliers and release delay ceiling
    localparam logic [31:0] PCT_SCALE = 32'h0000_0064;
    localparam logic [15:0] REL_DLY_MAX_S = 16'h0bb8;

    // Timing: one second at a 100 ns clock
    localparam int SECOND_S = 1;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SEC_CYCLES = SECOND_S * 1000000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PICK = 2'b01,
        ST_ACTIVE = 2'b11,
        ST_REL = 2'b10
    } alarm_state_t;
endpackage

// ==== verilog/delay_if.sv ====
// Handshake between the alarm sequencer and its seconds timer
`timescale 1ns/1ps
`default_nettype none
interface delay_if;
    logic run;
    logic tick;
    logic [15:0] limit;
    logic done;
    modport ctrl (output run, output tick, output limit, input done);
    modport tmr (input run, input tick, input limit, output done);
endinterface
`default_nettype wire

// ==== verilog/delay_timer.sv ====
// Seconds counter that reports when a held condition reaches its delay
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
    input wire logic sys_clk,
    input wire logic rst_n,
    delay_if.tmr dly
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    wire cnt_sat = &cnt_r;

    // Counting restarts whenever the condition drops out
    assign cnt_nxt = !dly.run ? 16'h0000 :
                     (dly.tick && !cnt_sat) ? cnt_r + 16'h0001 : cnt_r;
    assign dly.done = dly.run && (cnt_r >= dly.limit);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // count advances only on a second tick and clears when the condition drops
    a_hold_no_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dly.run && !dly.tick) |=> cnt_r == $past(cnt_r))
        else $error("Timer counted without a second tick");
    a_clear_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !dly.run |=> (cnt_r == 16'h0000))
        else $error("Timer kept count after condition dropped");
endmodule // delay_timer
`default_nettype wire

// ==== dv/reg_master.sv ====
// Register bus master model that drives the alarm record's register port
`timescale 1ns/1ps
`default_nettype none
module reg_master (
    input wire logic sys_clk,
    output logic reg_req,
    output logic reg_we,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err
);
    initial begin
        reg_req = 1'b0;
        reg_we = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // Request stands one cycle; the answer is taken once the ack edge has landed
    task automatic access(input logic we, input logic [15:0] addr, input logic [15:0] wdata,
            output logic [15:0] rdata, output logic ack, output logic err);
        @(posedge sys_clk);
        #1;
        reg_req = 1'b1;
        reg_we = we;
        reg_addr = addr;
        reg_wdata = wdata;
        @(posedge sys_clk);
        #1;
        rdata = reg_rdata;
        ack = reg_ack;
        err = reg_err;
        // Released lines show the inverse, so a stale value never looks live
        reg_req = 1'b0;
        reg_we = ~we;
        reg_addr = ~addr;
        reg_wdata = ~wdata;
    endtask
endmodule // reg_master
`default_nettype wire

// ==== dv/analog_alarm_record_tb.sv ====
// Self-checking bench for the analog alarm record
`timescale 1ns/1ps
`default_nettype none
module analog_alarm_record_tb;
    typedef struct packed {logic we; logic [15:0] addr; logic [15:0] data; logic err;} row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_req, reg_we, reg_ack, reg_err, act1, act2, act3, ev1, wc1;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, mon_reg_num, pick_ref_num, rel_ref_num;
    logic pick3 = 1'b0;
    logic [15:0] mon_value = 16'hffff;
    logic [15:0] ref_value = 16'h0001;
    int failures = 0;
    int tests_run = 0;
    // Reads carry the expected data in the data field
    row_t rows [38] = '{
        '{1'b0, 16'h176f, 16'h0101, 1'b0}, '{1'b0, 16'h1770, 16'h03f8, 1'b0},
        '{1'b0, 16'h1771, 16'h0101, 1'b0}, '{1'b0, 16'h1772, 16'h8000, 1'b0},
        '{1'b0, 16'h1773, 16'h8000, 1'b0}, '{1'b0, 16'h1774, 16'h8000, 1'b0},
        '{1'b0, 16'h1775, 16'h8000, 1'b0}, '{1'b0, 16'h1776, 16'h8000, 1'b0},
        '{1'b0, 16'h1777, 16'h8000, 1'b0}, '{1'b0, 16'h1778, 16'h0001, 1'b0},
        '{1'b0, 16'h1779, 16'h0000, 1'b0}, '{1'b0, 16'h177a, 16'h0000, 1'b0},
        '{1'b1, 16'h176f, 16'h0205, 1'b0}, '{1'b0, 16'h176f, 16'h0101, 1'b0},
        '{1'b1, 16'h176f, 16'h0004, 1'b0}, '{1'b0, 16'h176f, 16'h0001, 1'b0},
        '{1'b1, 16'h176f, 16'h0103, 1'b0}, '{1'b0, 16'h176f, 16'h0103, 1'b0},
        '{1'b1, 16'h1770, 16'h1234, 1'b0}, '{1'b0, 16'h1770, 16'h03f8, 1'b0},
        '{1'b1, 16'h1771, 16'h0404, 1'b0}, '{1'b0, 16'h1771, 16'h0101, 1'b0},
        '{1'b1, 16'h1776, 16'h0001, 1'b0}, '{1'b0, 16'h1776, 16'h8000, 1'b0},
        '{1'b1, 16'h1778, 16'h0003, 1'b0}, '{1'b0, 16'h1778, 16'h0001, 1'b0},
        '{1'b1, 16'h177a, 16'hffff, 1'b0}, '{1'b0, 16'h177a, 16'h0000, 1'b0},
        '{1'b1, 16'h1772, 16'h1234, 1'b0}, '{1'b0, 16'h1772, 16'h1234, 1'b0},
        '{1'b1, 16'h1775, 16'h4321, 1'b0}, '{1'b0, 16'h1775, 16'h4321, 1'b0},
        '{1'b1, 16'h1779, 16'h0200, 1'b0}, '{1'b0, 16'h1779, 16'h0200, 1'b0},
        '{1'b0, 16'h176e, 16'h0000, 1'b1}, '{1'b1, 16'h177b, 16'h5555, 1'b1},
        '{1'b1, 16'h176f, 16'h0101, 1'b0}, '{1'b0, 16'h176f, 16'h0101, 1'b0}};

    always #50 sys_clk = ~sys_clk;

    reg_master master (.sys_clk(sys_clk), .reg_req(reg_req), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err));

    analog_alarm_record #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err), .mon_value(mon_value),
        .pick_ref_value(ref_value), .rel_ref_value(ref_value), .mon_reg_num(mon_reg_num),
        .pick_ref_num(pick_ref_num), .rel_ref_num(rel_ref_num), .alarm_active(act1),
        .event_log(ev1), .wave_capture(wc1));

    // Pickup by bit test, dropout by scaled reference
    analog_alarm_record #(.TICK_CYCLES(4), .MODES(16'h0402)) DUT2 (.sys_clk(sys_clk),
        .rst_n(rst_n), .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(), .reg_ack(), .reg_err(), .mon_value(mon_value),
        .pick_ref_value(ref_value), .rel_ref_value(ref_value), .mon_reg_num(),
        .pick_ref_num(), .rel_ref_num(), .alarm_active(act2), .event_log(),
        .wave_capture());

    // Over alarm with pickup by scaled reference, dropout by bit test
    analog_alarm_record #(.TICK_CYCLES(4), .MODES(16'h0204), .ALARM_TYPE(16'h0000)) DUT3 (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(), .reg_ack(), .reg_err(),
        .mon_value(mon_value), .pick_ref_value(ref_value), .rel_ref_value(ref_value),
        .mon_reg_num(), .pick_ref_num(), .rel_ref_num(), .alarm_active(act3),
        .event_log(), .wave_capture());

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic access(input logic we, input logic [15:0] addr, input logic [15:0] data,
            input logic err_exp);
        logic [15:0] rd;
        logic ack;
        logic err;
        master.access(we, addr, data, rd, ack, err);
        check(16'(ack), 16'h0001, "ack");
        check(16'(err), 16'(err_exp), "error flag");
        if (!we)
            check(rd, data, "read data");
    endtask

    // Waits up to hi cycles for the alarm level; must says whether it has to arrive
    task automatic wait_level(input logic sel2, input logic lvl, input int lo, input int hi,
            input logic must, input logic ev_exp, input logic wc_exp);
        int n;
        logic found;
        n = 0;
        while (n < hi && (pick3 ? act3 : sel2 ? act2 : act1) !== lvl) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        found = ((pick3 ? act3 : sel2 ? act2 : act1) === lvl);
        check(16'(found == must && (!must || n >= lo)), 16'h0001, "alarm timing");
        if (must && lvl && !sel2) begin
            check(16'(ev1), 16'(ev_exp), "event pulse");
            check(16'(wc1), 16'(wc_exp), "capture pulse");
        end
        if (must && !found)
            stop_test();
    endtask

    initial begin
        row_t r;
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            access(r.we, r.addr, r.data, r.err);
        end
        check(mon_reg_num, 16'h03f8, "monitored number");
        check(pick_ref_num, 16'h1234, "reference number");
        check(rel_ref_num, 16'h4321, "release reference number");
        access(1'b1, 16'h1772, 16'h0064, 1'b0);
        access(1'b1, 16'h1774, 16'h0002, 1'b0);
        access(1'b1, 16'h1775, 16'h0064, 1'b0);
        access(1'b1, 16'h1777, 16'h0001, 1'b0);
        access(1'b1, 16'h1779, 16'h0000, 1'b0);
        access(1'b1, 16'h176f, 16'h0001, 1'b0);
        mon_value = 16'h0064;
        wait_level(1'b0, 1'b1, 0, 20, 1'b0, 1'b0, 1'b0);
        mon_value = 16'h0063;
        wait_level(1'b0, 1'b1, 4, 14, 1'b1, 1'b1, 1'b0);
        mon_value = 16'h0064;
        wait_level(1'b0, 1'b0, 1, 10, 1'b1, 1'b0, 1'b0);
        access(1'b1, 16'h1779, 16'h0200, 1'b0);
        mon_value = 16'h0063;
        wait_level(1'b0, 1'b1, 4, 14, 1'b1, 1'b1, 1'b1);
        mon_value = 16'h0064;
        wait_level(1'b0, 1'b0, 1, 10, 1'b1, 1'b0, 1'b0);
        access(1'b1, 16'h176f, 16'h0000, 1'b0);
        mon_value = 16'h0063;
        wait_level(1'b0, 1'b1, 4, 14, 1'b1, 1'b0, 1'b0);
        access(1'b1, 16'h176f, 16'h0101, 1'b0);
        wait_level(1'b0, 1'b0, 0, 3, 1'b1, 1'b0, 1'b0);
        wait_level(1'b0, 1'b1, 0, 20, 1'b0, 1'b0, 1'b0);
        mon_value = 16'h0003;
        access(1'b1, 16'h176f, 16'h0001, 1'b0);
        wait_level(1'b1, 1'b1, 0, 20, 1'b0, 1'b0, 1'b0);
        mon_value = 16'h0004;
        wait_level(1'b1, 1'b1, 4, 14, 1'b1, 1'b0, 1'b0);
        mon_value = 16'h0147;
        wait_level(1'b1, 1'b0, 0, 20, 1'b0, 1'b0, 1'b0);
        mon_value = 16'h0148;
        wait_level(1'b1, 1'b0, 1, 10, 1'b1, 1'b0, 1'b0);
        pick3 = 1'b1;
        wait_level(1'b1, 1'b1, 4, 14, 1'b1, 1'b0, 1'b0);
        mon_value = 16'h0203;
        wait_level(1'b1, 1'b0, 1, 10, 1'b1, 1'b0, 1'b0);
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        check(16'(act1), 16'h0000, "alarm after reset");
        access(1'b0, 16'h176f, 16'h0101, 1'b0);
        access(1'b0, 16'h1772, 16'h8000, 1'b0);
        access(1'b0, 16'h1779, 16'h0000, 1'b0);
        stop_test();
    end
endmodule // analog_alarm_record_tb
`default_nettype wire
